/* File: hw/timer_defines.svh */
// Overview of operation
// - Three independent presettable 16-bit down counters.
// - Counts accepted from 1 or 2 to 65536; a count of zero gives 65536 in binary (mode 3 here toggles its output on every clock pulse for a zero count).
// - Clock pulse counts; gate rising edge triggers.
// - Mode 0 output low from load until zero.
// - Mode 0 gate trigger starts the decrement.
// - Mode 1 output low after trigger until zero.
// - Mode 1 retrigger reloads and restarts period.
// - Mode 2 divides by N, one-clock low pulse.
// - Mode 2 repeats until gate goes low.
// - Mode 3 high (N+1)/2, low (N-1)/2 clocks.
// - Mode 3 decrements by two each clock pulse.
// - Mode 4 counts on load, one-clock low strobe.
// - Mode 4 low gate inhibits counting.
// - Mode 5 starts on gate edge, retriggerable strobe.
// - Mode 5 strobe only after full count.
// - Control byte: counter, access, mode, decimal fields.
// - Access zero latches count; counting undisturbed.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define CNT_W       16
`define AXI_AW      12
`define IDX_CTR0    10'h024
`define IDX_CTRL    10'h027
`define SLOT_CTRL   3'h3
`define UNMAPPED    3'h4
`define CB_SEL      7:6
`define CB_RW       5:4
`define CB_MODE     3:1
`define CB_BCD      0
`define SEL_NONE    2'h3
`define RW_LATCH    2'h0
`define RW_LSB      2'h1
`define RW_MSB      2'h2
`define RW_BOTH     2'h3
`define MODE0       3'h0
`define MODE1       3'h1
`define MODE2       3'h2
`define MODE3       3'h3
`define MODE4       3'h4
`define MODE5       3'h5
`define CNT_ONE     16'h0001
`define CNT_TWO     16'h0002
`define BCD_ZERO    4'h0
`define BCD_NINE    4'h9
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define BYTE_PAD    24'h000000
`define STATE_RST   '0
`endif

/* File: hw/timer_pkg.sv */
`include "timer_defines.svh"
package timer_pkg;
  typedef struct packed {
    logic [`CNT_W-1:0] cnt;
    logic              out;
    logic              run;
    logic              trig;
    logic              load_pend;
  } core_state_t;

  typedef struct packed {
    logic [1:0]        rw;
    logic [2:0]        mode;
    logic              bcd;
    logic [`CNT_W-1:0] cr;
    logic              wflip;
    logic              rflip;
    logic              latched;
    logic [`CNT_W-1:0] hold;
  } chan_t;

  typedef struct packed {
    chan_t [2:0]       ch;
    logic [2:0]        cfg_p;
    logic [2:0]        load_p;
    logic              aw_full;
    logic [`AXI_AW-1:0] aw_addr;
    logic              w_full;
    logic [7:0]        w_data;
    logic              w_lane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
  } top_state_t;
endpackage : timer_pkg

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps
`include "timer_defines.svh"
// Two-stage synchroniser per bit, plus a rising-edge pulse taken after it.
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= `STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q    = s_reg.s2;
  assign rise = s_reg.s2 & ~s_reg.s3;
endmodule : pin_sync

/* File: hw/counter_core.sv */
`timescale 1ns/1ps
`include "timer_defines.svh"
module counter_core (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              tick,
  input  wire logic              gate,
  input  wire logic              gate_rise,
  input  wire logic              cfg,
  input  wire logic              load,
  input  wire logic [`CNT_W-1:0] cr,
  input  wire logic [2:0]        mode,
  input  wire logic              bcd,
  output logic      [`CNT_W-1:0] cnt,
  output logic                   out,
  output logic                   null_count
);
  timer_pkg::core_state_t s_reg;
  timer_pkg::core_state_t s_next;
  logic [`CNT_W-1:0]      d1;
  logic [`CNT_W-1:0]      d2;

  // Binary or decimal decrement, wrapping through zero.
  function automatic logic [`CNT_W-1:0] dec_one(input logic [`CNT_W-1:0] x, input logic dec);
    logic [`CNT_W-1:0] r;
    logic              borrow;
    r      = x - `CNT_ONE;
    borrow = 1'h1;
    if (dec) begin
      r = x;
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (x[4*i+:4] == `BCD_ZERO) begin
            r[4*i+:4] = `BCD_NINE;
          end else begin
            r[4*i+:4] = x[4*i+:4] - 4'h1;
            borrow    = 1'h0;
          end
        end
      end
    end
    return r;
  endfunction : dec_one

  assign d1 = dec_one(s_reg.cnt, bcd);
  assign d2 = dec_one(d1, bcd);

  always_comb begin
    s_next = s_reg;
    if (gate_rise) begin
      s_next.trig = 1'h1;
      if (mode == `MODE0 && !s_reg.out) begin
        s_next.run = 1'h1;
      end
    end
    if (tick) begin
      case (mode)
        `MODE0: begin
          if (s_reg.load_pend) begin
            s_next.cnt       = cr;
            s_next.load_pend = 1'h0;
          end else if (s_reg.run) begin
            s_next.cnt = d1;
            if (s_reg.cnt == `CNT_ONE) begin
              s_next.out = 1'h1;
              s_next.run = 1'h0;
            end
          end
        end
        `MODE1, `MODE5: begin
          if (s_reg.trig) begin
            s_next.cnt       = cr;
            s_next.load_pend = 1'h0;
            s_next.trig      = gate_rise;
            s_next.run       = 1'h1;
            s_next.out       = (mode == `MODE5);
          end else if (s_reg.run) begin
            s_next.cnt = d1;
            if (s_reg.cnt == `CNT_ONE) begin
              s_next.run = 1'h0;
              s_next.out = (mode == `MODE1);
            end
          end else if (mode == `MODE5) begin
            s_next.out = 1'h1;
          end
        end
        `MODE2, `MODE3: begin
          if (s_reg.load_pend || s_reg.trig) begin
            s_next.cnt       = cr;
            s_next.out       = 1'h1;
            s_next.load_pend = 1'h0;
            s_next.trig      = gate_rise;
            s_next.run       = 1'h1;
          end else if (s_reg.run && gate) begin
            if (mode == `MODE2) begin
              if (!s_reg.out) begin
                s_next.cnt = cr;
                s_next.out = 1'h1;
              end else begin
                s_next.cnt = d1;
                if (s_reg.cnt == `CNT_TWO) begin
                  s_next.out = 1'h0;
                end
              end
            end else if (s_reg.cnt <= `CNT_TWO) begin
              // An odd count loses its low bit on the low half-wave only.
              s_next.out = !s_reg.out;
              s_next.cnt = s_reg.out ? {cr[`CNT_W-1:1], 1'h0} : cr;
            end else begin
              s_next.cnt = d2;
            end
          end
        end
        `MODE4: begin
          if (s_reg.load_pend) begin
            s_next.cnt       = cr;
            s_next.load_pend = 1'h0;
            s_next.run       = 1'h1;
          end else if (!s_reg.out) begin
            s_next.out = 1'h1;
          end else if (s_reg.run && gate) begin
            s_next.cnt = d1;
            if (s_reg.cnt == `CNT_ONE) begin
              s_next.out = 1'h0;
              s_next.run = 1'h0;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (load) begin
      s_next.load_pend = 1'h1;
      if (mode == `MODE0) begin
        s_next.out = 1'h0;
        s_next.run = 1'h0;
      end else if (mode == `MODE4) begin
        s_next.out = 1'h1;
      end
    end
    if (cfg) begin
      s_next.out       = (mode != `MODE0);
      s_next.run       = 1'h0;
      s_next.trig      = 1'h0;
      s_next.load_pend = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= `STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cnt        = s_reg.cnt;
  assign out        = s_reg.out;
  assign null_count = s_reg.load_pend;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic quiet;
  assign quiet = !cfg && !load && !s_reg.load_pend;
  property p_m0_low; load && !cfg && mode == `MODE0 |=> !out; endproperty
  a_m0_low: assert property (p_m0_low) else $error("mode 0 output not low after load");
  property p_m0_wait; mode == `MODE0 && quiet && !s_reg.run && !gate_rise |=> $stable(cnt); endproperty
  a_m0_wait: assert property (p_m0_wait) else $error("mode 0 counted without trigger");
  property p_m1_trig; mode == `MODE1 && tick && s_reg.trig && !cfg && !load |=> !out && cnt == $past(cr); endproperty
  a_m1_trig: assert property (p_m1_trig) else $error("mode 1 trigger did not start pulse");
  property p_m2_low; mode == `MODE2 && tick && gate && s_reg.run && out && cnt == `CNT_TWO && quiet && !s_reg.trig
    |=> !out && cnt == `CNT_ONE; endproperty
  a_m2_low: assert property (p_m2_low) else $error("mode 2 low pulse missing");
  property p_m2_hold; mode == `MODE2 && !gate && quiet && !s_reg.trig |=> $stable(cnt); endproperty
  a_m2_hold: assert property (p_m2_hold) else $error("mode 2 counted with gate low");
  property p_m3_dec2; mode == `MODE3 && tick && gate && s_reg.run && cnt > `CNT_TWO && !bcd && quiet && !s_reg.trig
    |=> cnt == $past(cnt) - `CNT_TWO; endproperty
  a_m3_dec2: assert property (p_m3_dec2) else $error("mode 3 did not step by two");
  property p_m3_flip; mode == `MODE3 && tick && gate && s_reg.run && cnt <= `CNT_TWO && quiet && !s_reg.trig
    |=> out != $past(out); endproperty
  a_m3_flip: assert property (p_m3_flip) else $error("mode 3 half-wave did not toggle");
  property p_m4_strobe; mode == `MODE4 && tick && !out && quiet |=> out; endproperty
  a_m4_strobe: assert property (p_m4_strobe) else $error("mode 4 strobe longer than one clock");
  property p_m4_inh; mode == `MODE4 && !gate && quiet |=> $stable(cnt); endproperty
  a_m4_inh: assert property (p_m4_inh) else $error("mode 4 counted with gate low");
  property p_m5_wait; mode == `MODE5 && out && !s_reg.run && !s_reg.trig && !gate_rise && !cfg && !load |=> out; endproperty
  a_m5_wait: assert property (p_m5_wait) else $error("mode 5 strobe without trigger");
  property p_dec1; mode == `MODE4 && tick && gate && s_reg.run && out && !bcd && quiet
    |=> cnt == $past(cnt) - `CNT_ONE; endproperty
  a_dec1: assert property (p_dec1) else $error("count step not one");
  c_m1_pulse: cover property (mode == `MODE1 && $fell(out));
  c_m3_wave: cover property (mode == `MODE3 && $rose(out));
  c_m5_strobe: cover property (mode == `MODE5 && $fell(out));
endmodule : counter_core

/* File: hw/three_channel_interval_timer.sv */
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "timer_defines.svh"
// Counter data bytes sit in bits 7:0; a write with wstrb[0] low is answered but ignored.
// Counter clock and gate pins are sampled on clk, so they must stay well below clk/4.
module three_channel_interval_timer (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic      [1:0]         bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [`AXI_AW-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic      [31:0]        rdata,
  output logic      [1:0]         rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic [2:0]         ctr_clk,
  input  wire logic [2:0]         ctr_gate,
  output logic      [2:0]         ctr_out
);
  timer_pkg::top_state_t      s_reg;
  timer_pkg::top_state_t      s_next;
  logic [5:0]                 pin_q;
  logic [5:0]                 pin_rise;
  logic [2:0][`CNT_W-1:0]     core_cnt;
  logic                       wr_go;
  logic [2:0]                 wr_slot;

  // Maps a byte address onto counters 0..2, the control slot, or unmapped.
  function automatic logic [2:0] slot_of(input logic [`AXI_AW-1:0] a);
    logic [`AXI_AW-3:0] idx;
    idx = a[`AXI_AW-1:2];
    if (a[1:0] != 2'h0) begin
      return `UNMAPPED;
    end else if (idx >= `IDX_CTR0 && idx <= `IDX_CTRL) begin
      return 3'(idx - `IDX_CTR0);
    end else begin
      return `UNMAPPED;
    end
  endfunction : slot_of

  // Modes 6 and 7 alias onto 2 and 3.
  function automatic logic [2:0] mode_norm(input logic [2:0] m);
    if (m[1]) begin
      return {1'h0, m[1:0]};
    end else begin
      return m;
    end
  endfunction : mode_norm

  pin_sync #(
    .W (6)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({ctr_gate, ctr_clk}),
    .q    (pin_q),
    .rise (pin_rise)
  );

  for (genvar i = 0; i < 3; i++) begin : g_ctr
    counter_core u_core (
      .clk        (clk),
      .rstn       (rstn),
      .tick       (pin_rise[i]),
      .gate       (pin_q[i+3]),
      .gate_rise  (pin_rise[i+3]),
      .cfg        (s_reg.cfg_p[i]),
      .load       (s_reg.load_p[i]),
      .cr         (s_reg.ch[i].cr),
      .mode       (mode_norm(s_reg.ch[i].mode)),
      .bcd        (s_reg.ch[i].bcd),
      .cnt        (core_cnt[i]),
      .out        (ctr_out[i]),
      .null_count ()
    );
  end

  assign wr_go   = s_reg.aw_full & s_reg.w_full & ~s_reg.bvalid;
  assign wr_slot = slot_of(s_reg.aw_addr);

  always_comb begin
    timer_pkg::chan_t  c;
    logic [2:0]        k;
    logic [`CNT_W-1:0] v;
    c = '0;
    k = '0;
    v = '0;
    s_next        = s_reg;
    s_next.cfg_p  = '0;
    s_next.load_p = '0;
    if (awvalid && awready) begin
      s_next.aw_full = 1'h1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_full = 1'h1;
      s_next.w_data = wdata[7:0];
      s_next.w_lane = wstrb[0];
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'h0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'h0;
    end
    if (wr_go) begin
      s_next.aw_full = 1'h0;
      s_next.w_full  = 1'h0;
      s_next.bvalid  = 1'h1;
      s_next.bresp   = (wr_slot == `UNMAPPED) ? `RESP_SLVERR : `RESP_OKAY;
      if (wr_slot == `SLOT_CTRL && s_reg.w_lane) begin
        k = {1'h0, s_reg.w_data[`CB_SEL]};
        if (s_reg.w_data[`CB_SEL] != `SEL_NONE) begin
          c = s_next.ch[k[1:0]];
          if (s_reg.w_data[`CB_RW] == `RW_LATCH) begin
            // A second latch before the held value is read has no effect.
            if (!c.latched) begin
              c.latched = 1'h1;
              c.hold    = core_cnt[k[1:0]];
            end
          end else begin
            c.rw      = s_reg.w_data[`CB_RW];
            c.mode    = s_reg.w_data[`CB_MODE];
            c.bcd     = s_reg.w_data[`CB_BCD];
            c.wflip   = 1'h0;
            c.rflip   = 1'h0;
            c.latched = 1'h0;
            s_next.cfg_p[k[1:0]] = 1'h1;
          end
          s_next.ch[k[1:0]] = c;
        end
      end else if (wr_slot < `SLOT_CTRL && s_reg.w_lane) begin
        k = wr_slot;
        c = s_next.ch[k[1:0]];
        case (c.rw)
          `RW_LSB: begin
            c.cr = {8'h00, s_reg.w_data};
            s_next.load_p[k[1:0]] = 1'h1;
          end
          `RW_MSB: begin
            c.cr = {s_reg.w_data, 8'h00};
            s_next.load_p[k[1:0]] = 1'h1;
          end
          `RW_BOTH: begin
            if (!c.wflip) begin
              c.cr[7:0] = s_reg.w_data;
              c.wflip   = 1'h1;
            end else begin
              c.cr[15:8] = s_reg.w_data;
              c.wflip    = 1'h0;
              s_next.load_p[k[1:0]] = 1'h1;
            end
          end
          default: begin
          end
        endcase
        s_next.ch[k[1:0]] = c;
      end
    end
    if (arvalid && arready) begin
      k = slot_of(araddr);
      s_next.rvalid = 1'h1;
      s_next.rresp  = (k == `UNMAPPED) ? `RESP_SLVERR : `RESP_OKAY;
      s_next.rdata  = 8'h00;
      if (k < `SLOT_CTRL) begin
        c = s_next.ch[k[1:0]];
        v = c.latched ? c.hold : core_cnt[k[1:0]];
        case (c.rw)
          `RW_MSB: begin
            s_next.rdata = v[15:8];
            c.latched    = 1'h0;
          end
          `RW_BOTH: begin
            if (c.rflip) begin
              s_next.rdata = v[15:8];
              c.rflip      = 1'h0;
              c.latched    = 1'h0;
            end else begin
              s_next.rdata = v[7:0];
              c.rflip      = 1'h1;
            end
          end
          default: begin
            s_next.rdata = v[7:0];
            c.latched    = 1'h0;
          end
        endcase
        s_next.ch[k[1:0]] = c;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= `STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = ~s_reg.aw_full & ~s_reg.bvalid;
  assign wready  = ~s_reg.w_full & ~s_reg.bvalid;
  assign arready = ~s_reg.rvalid;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign rvalid  = s_reg.rvalid;
  assign rresp   = s_reg.rresp;
  assign rdata   = {`BYTE_PAD, s_reg.rdata};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_latch; $rose(s_reg.ch[0].latched) |-> s_reg.ch[0].hold == $past(core_cnt[0]); endproperty
  a_latch: assert property (p_latch) else $error("latched value differs from count");
  property p_hold; s_reg.ch[0].latched ##1 s_reg.ch[0].latched |-> $stable(s_reg.ch[0].hold); endproperty
  a_hold: assert property (p_hold) else $error("held value moved while latched");
  property p_ctrl; wr_go && s_reg.w_lane && wr_slot == `SLOT_CTRL && s_reg.w_data[7:6] == 2'h0
    && s_reg.w_data[5:4] != `RW_LATCH |=> s_reg.cfg_p[0] && s_reg.ch[0].mode == $past(s_reg.w_data[3:1]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control byte not applied to counter 0");
  c_latch_read: cover property (s_reg.ch[0].latched ##[1:20] !s_reg.ch[0].latched);
endmodule : three_channel_interval_timer

/* File: dv/three_channel_interval_timer_tb.sv */
`timescale 1ns/1ps
`include "timer_defines.svh"
module three_channel_interval_timer_tb;
  localparam logic [11:0] CTR0_ADDR = {`IDX_CTR0, 2'b00};
  localparam logic [11:0] CTRL_ADDR = {`IDX_CTRL, 2'b00};
  logic        clk;
  logic        rstn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [2:0]  ctr_clk;
  logic [2:0]  ctr_gate;
  logic [2:0]  ctr_out;
  int          n_errors;
  int          num_checks;
  logic        q[$];
  logic [31:0] d;

  three_channel_interval_timer u_dut (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Ready and valid are looked at on the falling edge, so the rising edge after it is the handshake.
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw_p, w_p, ta, tw, b;
    logic [1:0] r;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, v};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    while (aw_p || w_p) begin
      @(negedge clk);
      ta = aw_p && awready;
      tw = w_p && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      aw_p = aw_p && !ta;
      w_p  = w_p && !tw;
    end
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      b = bvalid;
      r = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    check({30'h0, r}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
    logic t;
    logic [1:0] r;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    check({30'h0, r}, {30'h0, er}, "read response");
  endtask : rd

  task automatic pulse(input int ch);
    @(posedge clk);
    ctr_clk[ch] <= 1'b1;
    repeat (4) @(posedge clk);
    ctr_clk[ch] <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    q.push_back(ctr_out[ch]);
  endtask : pulse

  task automatic set_gate(input int ch, input logic v);
    @(posedge clk);
    ctr_gate[ch] <= v;
    repeat (6) @(posedge clk);
  endtask : set_gate

  // Reference output, sampled after each counter clock pulse; index 0 is the pulse that loads the count, or in mode 0 the first pulse after the gate trigger.
  function automatic logic exp_out(input int mode, input int n, input int i);
    case (mode)
      0: return i >= n - 1;
      1: return i >= n;
      default: return i != n;
    endcase
  endfunction : exp_out

  task automatic scen(input int mode, input int n);
    int ch, len, hi, lo, nruns;
    logic [11:0] ca;
    logic [31:0] v;
    ch = mode % 3;
    ca = CTR0_ADDR + 12'(4 * ch);
    set_gate(ch, mode == 2 || mode == 3 || mode == 4);
    wr(CTRL_ADDR, {2'(ch), 2'b11, 3'(mode), 1'b0}, `RESP_OKAY);
    repeat (4) @(posedge clk);
    check({31'h0, ctr_out[ch]}, {31'h0, mode != 0}, "output after control");
    wr(ca, 8'(n), `RESP_OKAY);
    wr(ca, 8'h00, `RESP_OKAY);
    if (mode == 0) begin
      pulse(ch);
      wr(CTRL_ADDR, {2'(ch), 6'h00}, `RESP_OKAY);
      rd(ca, `RESP_OKAY, v);
      check(v, 32'(n), "latched low byte");
      rd(ca, `RESP_OKAY, v);
      check(v, 32'h0, "latched high byte");
    end
    if (mode == 0 || mode == 1 || mode == 5) set_gate(ch, 1'b1);
    q.delete();
    repeat (3 * n + 6) pulse(ch);
    if (mode < 2 || mode > 3) begin
      foreach (q[i]) check({31'h0, q[i]}, {31'h0, exp_out(mode, n, i)}, "output sequence");
    end else begin
      hi = (mode == 2) ? n - 1 : (n + 1) / 2;
      lo = (mode == 2) ? 1 : (n - 1) / 2;
      len = 1;
      nruns = 0;
      for (int i = 1; i < q.size(); i++) begin
        if (q[i] === q[i-1]) begin
          len++;
        end else begin
          if (nruns > 0) check(32'(len), 32'(q[i-1] ? hi : lo), "run length");
          nruns++;
          len = 1;
        end
      end
      check({31'h0, nruns >= 4}, 32'h1, "periodic output");
    end
    if (mode == 4) begin
      set_gate(ch, 1'b0);
      wr(ca, 8'(n), `RESP_OKAY);
      wr(ca, 8'h00, `RESP_OKAY);
      q.delete();
      repeat (2 * n + 2) pulse(ch);
      foreach (q[i]) check({31'h0, q[i]}, 32'h1, "inhibited strobe");
    end
  endtask : scen

  initial begin
    rstn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'h1;
    ctr_clk = 3'h0;
    ctr_gate = 3'h0;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(47805));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({awready, arready, bvalid, rvalid, ctr_out}, {4'b1100, 3'h0}, "reset state");
    wr(12'h000, 8'h5a, `RESP_SLVERR);
    wr(CTR0_ADDR + 12'h001, 8'h5a, `RESP_SLVERR);
    rd(12'h000, `RESP_SLVERR, d);
    check(d, 32'h0, "unmapped read data");
    rd(CTRL_ADDR, `RESP_OKAY, d);
    check(d, 32'h0, "control read data");
    for (int m = 0; m < 6; m++) scen(m, m == 3 ? 3 + 2 * ($urandom % 3) : 2 + $urandom % 5);
    results();
  end

  initial begin
    #250000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule : three_channel_interval_timer_tb
